// ### core/sysopt_pkg.sv
// system options and part identification register bank: shared constants and types
// assumes an 8-bit register port with byte-wide data
package sysopt_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   // register offsets
   localparam logic [7:0] OFS_OPTIONS_ONE = 8'h00;
   localparam logic [7:0] OFS_OPTIONS_TWO = 8'h01;
   localparam logic [7:0] OFS_PART_ID_HI  = 8'h02;
   localparam logic [7:0] OFS_PART_ID_LO  = 8'h03;

   // first options register bit positions
   localparam int unsigned BIT_WDOG_EN    = 7;
   localparam int unsigned BIT_WDOG_LONG  = 6;
   localparam int unsigned BIT_HALT_OK    = 5;
   localparam int unsigned BIT_DEBUG_PIN  = 1;
   localparam int unsigned BIT_RESET_PIN  = 0;

   // second options register bit positions
   localparam int unsigned BIT_WDOG_CLK   = 7;
   localparam int unsigned BIT_SPI_SEL    = 2;
   localparam int unsigned BIT_TWI_SEL    = 1;
   localparam int unsigned BIT_CMP_CAP    = 0;

   // reset values
   localparam logic RST_WDOG_EN   = 1'b1;
   localparam logic RST_WDOG_LONG = 1'b1;
   localparam logic RST_HALT_OK   = 1'b0;
   localparam logic RST_DEBUG_PIN = 1'b1;
   localparam logic RST_RESET_PIN = 1'b1;
   localparam logic RST_WDOG_CLK  = 1'b0;
   localparam logic RST_SPI_SEL   = 1'b0;
   localparam logic RST_TWI_SEL   = 1'b0;
   localparam logic RST_CMP_CAP   = 1'b0;

   // part id layout; reserved upper nibble of the high byte reads this value
   localparam int unsigned PART_ID_W    = 12;
   localparam logic [3:0]  ID_RSVD_READ = 4'h0;

   // watchdog period defaults, in ticks of the selected clock
   localparam int unsigned WDOG_CNT_W      = 20;
   localparam int unsigned WDOG_SHORT_SLOW = 32;
   localparam int unsigned WDOG_LONG_SLOW  = 256;
   localparam int unsigned WDOG_SHORT_BUS  = 8192;
   localparam int unsigned WDOG_LONG_BUS   = 262144;

   typedef struct packed {
      logic watchdog_enable;
      logic watchdog_long_timeout;
      logic halt_mode_permit;
      logic debug_pin_enable;
      logic reset_pin_enable;
   } options_one_s;

   typedef struct packed {
      logic watchdog_clock_select;
      logic serial_peripheral_pin_select;
      logic two_wire_pin_select;
      logic comparator_to_capture;
   } options_two_s;

endpackage

// ### core/system_options_id_regs.sv
// system options and part identification register bank with watchdog and halt gate
// assumes one clock, synchronous inputs, a strobe-based register port and
// a separate power-on/low-voltage reset that also asserts resetn_i
`timescale 1ns/1ps

module system_options_id_regs #(
   parameter logic [11:0] PART_ID         = 12'h5a3,  // arbitrary value
   parameter int unsigned WDOG_SHORT_SLOW = sysopt_pkg::WDOG_SHORT_SLOW,
   parameter int unsigned WDOG_LONG_SLOW  = sysopt_pkg::WDOG_LONG_SLOW,
   parameter int unsigned WDOG_SHORT_BUS  = sysopt_pkg::WDOG_SHORT_BUS,
   parameter int unsigned WDOG_LONG_BUS   = sysopt_pkg::WDOG_LONG_BUS
) (
   input  wire logic                            clk_i,
   input  wire logic                            resetn_i,
   input  wire logic                            por_resetn_i,
   input  wire logic [sysopt_pkg::ADDR_W-1:0]   addr_i,
   input  wire logic [sysopt_pkg::DATA_W-1:0]   wdata_i,
   input  wire logic                            we_i,
   input  wire logic                            re_i,
   output logic      [sysopt_pkg::DATA_W-1:0]   rdata_o,
   input  wire logic                            slow_tick_i,
   input  wire logic                            watchdog_service_i,
   input  wire logic                            halt_request_i,
   input  wire logic                            comparator_output_i,
   input  wire logic                            capture_pin_i,
   output logic                                 watchdog_reset_o,
   output logic                                 halt_enter_o,
   output logic                                 illegal_op_reset_o,
   output sysopt_pkg::options_one_s             options_one_o,
   output sysopt_pkg::options_two_s             options_two_o,
   output logic                                 reset_pullup_o,
   output logic                                 capture_ch0_o
);

   function automatic logic hit(input logic [sysopt_pkg::ADDR_W-1:0] a,
                                input logic [sysopt_pkg::ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   sysopt_pkg::options_one_s opt1_q;
   logic                     reset_pin_q;
   sysopt_pkg::options_two_s opt2_q;
   logic                     lock_one_q;
   logic                     lock_two_q;
   logic [sysopt_pkg::DATA_W-1:0] rdata_q;
   logic [sysopt_pkg::WDOG_CNT_W-1:0] wdog_cnt_q;
   logic [sysopt_pkg::WDOG_CNT_W-1:0] wdog_limit;
   logic                     wdog_step;
   logic                     wdog_bite_q;
   logic                     halt_q;
   logic                     illop_q;
   logic                     pullup_q;
   logic                     capture_q;
   logic                     wr_one;
   logic                     wr_two;

   // options one takes only the first write after reset; options two takes every write, but its clock select bit only the first
   assign wr_one = we_i && hit(addr_i, sysopt_pkg::OFS_OPTIONS_ONE) && !lock_one_q;
   assign wr_two = we_i && hit(addr_i, sysopt_pkg::OFS_OPTIONS_TWO);

   // lock flags set by first write
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lock_one_q <= 1'b0;
         lock_two_q <= 1'b0;
      end else begin
         if (wr_one) begin
            lock_one_q <= 1'b1;
         end
         if (wr_two) begin
            lock_two_q <= 1'b1;
         end
      end
   end

   // debug pin back after any reset
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         opt1_q.watchdog_enable       <= sysopt_pkg::RST_WDOG_EN;
         opt1_q.watchdog_long_timeout <= sysopt_pkg::RST_WDOG_LONG;
         opt1_q.halt_mode_permit      <= sysopt_pkg::RST_HALT_OK;
         opt1_q.debug_pin_enable      <= sysopt_pkg::RST_DEBUG_PIN;
      end else if (wr_one) begin
         opt1_q.watchdog_enable       <= wdata_i[sysopt_pkg::BIT_WDOG_EN];
         opt1_q.watchdog_long_timeout <= wdata_i[sysopt_pkg::BIT_WDOG_LONG];
         opt1_q.halt_mode_permit      <= wdata_i[sysopt_pkg::BIT_HALT_OK];
         opt1_q.debug_pin_enable      <= wdata_i[sysopt_pkg::BIT_DEBUG_PIN];
      end
   end
   assign opt1_q.reset_pin_enable = reset_pin_q;

   // reset pin bit survives non-power resets
   always_ff @(posedge clk_i or negedge por_resetn_i) begin
      if (!por_resetn_i) begin
         reset_pin_q <= sysopt_pkg::RST_RESET_PIN;
      end else if (wr_one) begin
         reset_pin_q <= wdata_i[sysopt_pkg::BIT_RESET_PIN];
      end
   end

   // clock select is write-once, pin routing stays writable
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         opt2_q.watchdog_clock_select        <= sysopt_pkg::RST_WDOG_CLK;
         opt2_q.serial_peripheral_pin_select <= sysopt_pkg::RST_SPI_SEL;
         opt2_q.two_wire_pin_select          <= sysopt_pkg::RST_TWI_SEL;
         opt2_q.comparator_to_capture        <= sysopt_pkg::RST_CMP_CAP;
      end else if (wr_two) begin
         if (!lock_two_q) begin
            opt2_q.watchdog_clock_select <= wdata_i[sysopt_pkg::BIT_WDOG_CLK];
         end
         opt2_q.serial_peripheral_pin_select <= wdata_i[sysopt_pkg::BIT_SPI_SEL];
         opt2_q.two_wire_pin_select          <= wdata_i[sysopt_pkg::BIT_TWI_SEL];
         opt2_q.comparator_to_capture        <= wdata_i[sysopt_pkg::BIT_CMP_CAP];
      end
   end

   // read data, one cycle after strobe only
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_q <= 8'h00;
      end else if (!re_i) begin
         rdata_q <= 8'h00;
      end else if (hit(addr_i, sysopt_pkg::OFS_OPTIONS_ONE)) begin
         rdata_q <= {opt1_q.watchdog_enable, opt1_q.watchdog_long_timeout,
                     opt1_q.halt_mode_permit, 3'h0,
                     opt1_q.debug_pin_enable, reset_pin_q};
      end else if (hit(addr_i, sysopt_pkg::OFS_OPTIONS_TWO)) begin
         rdata_q <= {opt2_q.watchdog_clock_select, 4'h0,
                     opt2_q.serial_peripheral_pin_select,
                     opt2_q.two_wire_pin_select, opt2_q.comparator_to_capture};
      end else if (hit(addr_i, sysopt_pkg::OFS_PART_ID_HI)) begin
         // id high nibble, reserved bits fixed
         rdata_q <= {sysopt_pkg::ID_RSVD_READ, PART_ID[11:8]};
      end else if (hit(addr_i, sysopt_pkg::OFS_PART_ID_LO)) begin
         rdata_q <= PART_ID[7:0];
      end else begin
         rdata_q <= 8'h00;
      end
   end

   // period from length bit and clock select
   always_comb begin
      if (opt2_q.watchdog_clock_select) begin
         wdog_limit = opt1_q.watchdog_long_timeout ?
                      sysopt_pkg::WDOG_CNT_W'(WDOG_LONG_BUS - 1) :
                      sysopt_pkg::WDOG_CNT_W'(WDOG_SHORT_BUS - 1);
         wdog_step  = 1'b1;
      end else begin
         wdog_limit = opt1_q.watchdog_long_timeout ?
                      sysopt_pkg::WDOG_CNT_W'(WDOG_LONG_SLOW - 1) :
                      sysopt_pkg::WDOG_CNT_W'(WDOG_SHORT_SLOW - 1);
         wdog_step  = slow_tick_i;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wdog_cnt_q  <= '0;
         wdog_bite_q <= 1'b0;
      end else begin
         wdog_bite_q <= 1'b0;
         if (!opt1_q.watchdog_enable || watchdog_service_i) begin
            wdog_cnt_q <= '0;
         end else if (wdog_step) begin
            if (wdog_cnt_q >= wdog_limit) begin
               wdog_cnt_q  <= '0;
               wdog_bite_q <= 1'b1;
            end else begin
               wdog_cnt_q <= wdog_cnt_q + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         halt_q  <= 1'b0;
         illop_q <= 1'b0;
      end else begin
         halt_q  <= halt_request_i && opt1_q.halt_mode_permit;
         illop_q <= halt_request_i && !opt1_q.halt_mode_permit;
      end
   end

   // registered pin-side controls; one cycle behind the option bits
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pullup_q  <= 1'b0;
         capture_q <= 1'b0;
      end else begin
         pullup_q  <= reset_pin_q;
         capture_q <= opt2_q.comparator_to_capture ? comparator_output_i : capture_pin_i;
      end
   end

   assign rdata_o            = rdata_q;
   assign watchdog_reset_o   = wdog_bite_q;
   assign halt_enter_o       = halt_q;
   assign illegal_op_reset_o = illop_q;
   // pin function selects leave as flops
   assign options_one_o      = opt1_q;
   assign options_two_o      = opt2_q;
   assign reset_pullup_o     = pullup_q;
   assign capture_ch0_o      = capture_q;

endmodule

// ### bench/sysopt_regs_monitor.sv
// checker for the options and part id register bank
// assumes it is bound to the bank's top module and sees only its ports
`timescale 1ns/1ps
module sysopt_regs_monitor #(
   parameter logic [11:0] PART_ID = 12'h5a3
) (
   input wire logic                     clk_i,
   input wire logic                     resetn_i,
   input wire logic [7:0]               addr_i,
   input wire logic [7:0]               wdata_i,
   input wire logic                     we_i,
   input wire logic                     re_i,
   input wire logic [7:0]               rdata_o,
   input wire logic                     halt_request_i,
   input wire logic                     comparator_output_i,
   input wire logic                     capture_pin_i,
   input wire logic                     halt_enter_o,
   input wire logic                     illegal_op_reset_o,
   input wire sysopt_pkg::options_one_s options_one_o,
   input wire sysopt_pkg::options_two_s options_two_o,
   input wire logic                     reset_pullup_o,
   input wire logic                     capture_ch0_o
);
   // own lock copies, so a lock that never sets shows up
   logic lock1_q;
   logic lock2_q;
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lock1_q <= 1'b0;
         lock2_q <= 1'b0;
      end else begin
         lock1_q <= lock1_q | (we_i && addr_i == sysopt_pkg::OFS_OPTIONS_ONE);
         lock2_q <= lock2_q | (we_i && addr_i == sysopt_pkg::OFS_OPTIONS_TWO);
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   sequence wr_one_s;
      we_i && addr_i == sysopt_pkg::OFS_OPTIONS_ONE;
   endsequence
   sequence wr_two_s;
      we_i && addr_i == sysopt_pkg::OFS_OPTIONS_TWO;
   endsequence
   first_take_a: assert property ((!lock1_q ##0 wr_one_s) |=>
      options_one_o.halt_mode_permit == $past(wdata_i[5]) &&
      options_one_o.watchdog_enable == $past(wdata_i[7])) else $error("first write not taken");
   lock_one_a: assert property ((lock1_q ##0 wr_one_s) |=> $stable(options_one_o))
      else $error("locked options changed");
   lock_clk_a: assert property ((lock2_q ##0 wr_two_s) |=>
      $stable(options_two_o.watchdog_clock_select)) else $error("locked clock select changed");
   halt_ok_a: assert property (halt_request_i && options_one_o.halt_mode_permit |=>
      halt_enter_o && !illegal_op_reset_o) else $error("permitted halt not entered");
   halt_bad_a: assert property (halt_request_i && !options_one_o.halt_mode_permit |=>
      illegal_op_reset_o && !halt_enter_o) else $error("forbidden halt not refused");
   pullup_a: assert property ($past(resetn_i) |->
      reset_pullup_o == $past(options_one_o.reset_pin_enable)) else $error("pull-up mismatch");
   id_low_a: assert property (re_i && addr_i == sysopt_pkg::OFS_PART_ID_LO |=>
      rdata_o == PART_ID[7:0]) else $error("low id read wrong");
   capture_a: assert property ($past(resetn_i) |-> capture_ch0_o ==
      ($past(options_two_o.comparator_to_capture) ? $past(comparator_output_i)
      : $past(capture_pin_i))) else $error("capture routing wrong");
endmodule
bind system_options_id_regs sysopt_regs_monitor #(.PART_ID(PART_ID)) i_sysopt_regs_monitor (
   .clk_i, .resetn_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .halt_request_i,
   .comparator_output_i, .capture_pin_i, .halt_enter_o, .illegal_op_reset_o,
   .options_one_o, .options_two_o, .reset_pullup_o, .capture_ch0_o);

// ### bench/system_options_id_regs_bench.sv
// register-level bench for the options and part id bank
// assumes the bank and its package are compiled first; slow tick is driven here
`timescale 1ns/1ps
module system_options_id_regs_bench;
   localparam logic [11:0] ID   = 12'h3c7;  // arbitrary value
   localparam int          LBUS = 32;
   localparam int          LSLOW = 8;
   logic clk_i, resetn_i, por_n, we_i, re_i, svc, halt, cmp, pin, tick;
   logic [7:0] addr_i, wdata_i, rdata_o, d;
   logic wdog, hen, ilr, pull, cap;
   sysopt_pkg::options_one_s o1;
   sysopt_pkg::options_two_s o2;
   int fail_count, n_tests, cyc, n, wd_n, k;
   // short watchdog limits keep the run brief
   system_options_id_regs #(.PART_ID(ID), .WDOG_SHORT_SLOW(4), .WDOG_LONG_SLOW(LSLOW),
      .WDOG_SHORT_BUS(16), .WDOG_LONG_BUS(LBUS)) i_system_options_id_regs (
      .clk_i(clk_i), .resetn_i(resetn_i), .por_resetn_i(por_n), .addr_i(addr_i),
      .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .slow_tick_i(tick),
      .watchdog_service_i(svc), .halt_request_i(halt), .comparator_output_i(cmp),
      .capture_pin_i(pin), .watchdog_reset_o(wdog), .halt_enter_o(hen),
      .illegal_op_reset_o(ilr), .options_one_o(o1), .options_two_o(o2),
      .reset_pullup_o(pull), .capture_ch0_o(cap));
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_i);
      we_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge clk_i);
      we_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_i);
      re_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      re_i <= 1'b0;
      #1 v = rdata_o;
   endtask
   task automatic halt_chk(input logic ok);
      @(posedge clk_i);
      halt <= 1'b1;
      @(posedge clk_i);
      halt <= 1'b0;
      #1 chk("halt_enter", {7'h0, hen}, {7'h0, ok});
      chk("illegal_op", {7'h0, ilr}, {7'h0, ~ok});
   endtask
   // por keeps its line low too, as the system does
   task automatic rst(input logic por);
      @(posedge clk_i);
      resetn_i <= 1'b0;
      por_n <= ~por;
      repeat (4) @(posedge clk_i);
      resetn_i <= 1'b1;
      por_n <= 1'b1;
   endtask
   task automatic end_sim();
      $display("mismatches %0d, checks %0d", fail_count, n_tests);
      if (fail_count == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (wdog === 1'b1)
         wd_n++;
      if (cyc == 3000) begin
         fail_count++;
         end_sim();
      end
   end
   initial begin
      {resetn_i, por_n, we_i, re_i, svc, halt, cmp, pin, tick, addr_i, wdata_i} = '0;
      {fail_count, n_tests, cyc, wd_n} = '0;
      repeat (4) @(posedge clk_i);
      resetn_i <= 1'b1;
      por_n <= 1'b1;
      for (k = 0; k < 2; k++) begin
         rd(8'h02, d);
         chk("id_high", d, {sysopt_pkg::ID_RSVD_READ, ID[11:8]});
         rd(8'h03, d);
         chk("id_low", d, ID[7:0]);
         wr(8'h02, 8'hff);
         wr(8'h03, 8'h00);
      end
      rd(8'h10, d);
      chk("unmapped", d, 8'h00);
      rd(8'h00, d);
      chk("opt1_reset", d & 8'he3, 8'hc3);
      wr(8'h01, 8'h80);
      @(posedge clk_i);
      svc <= 1'b1;
      @(posedge clk_i);
      svc <= 1'b0;
      n = 0;
      while (wdog !== 1'b1 && n < 100) begin
         @(posedge clk_i);
         #1 n++;
      end
      chk("wdog_period", 8'(n >= LBUS - 1 && n <= LBUS + 2), 8'h01);
      wr(8'h01, 8'h07);
      rd(8'h01, d);
      chk("opt2", d & 8'h87, 8'h87);
      chk("opt2_out", {4'h0, o2}, 8'h0f);
      @(posedge clk_i);
      cmp <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1 chk("capture", {7'h0, cap}, 8'h01);
      wr(8'h00, 8'h60);
      wr(8'h00, 8'h83);
      rd(8'h00, d);
      chk("opt1_lock", d & 8'he3, 8'h60);
      chk("opt1_out", {3'h0, o1}, 8'h0c);
      chk("pullup_off", {7'h0, pull}, 8'h00);
      halt_chk(1'b1);
      n = wd_n;
      repeat (2 * LBUS) @(posedge clk_i);
      chk("wdog_off", 8'(wd_n - n), 8'h00);
      rst(1'b0);
      rd(8'h00, d);
      chk("opt1_sys_rst", d & 8'he3, 8'hc2);
      halt_chk(1'b0);
      wr(8'h00, 8'h20);
      rd(8'h00, d);
      chk("opt1_relock", d & 8'he3, 8'h20);
      rst(1'b1);
      rd(8'h00, d);
      chk("opt1_por", d & 8'h01, 8'h01);
      chk("pullup_on", {7'h0, pull}, 8'h01);
      wr(8'h00, 8'hc3);
      wr(8'h00, 8'h00);
      rd(8'h00, d);
      chk("opt1_init", d & 8'he3, 8'hc3);
      @(posedge clk_i);
      tick <= 1'b1;
      svc <= 1'b1;
      @(posedge clk_i);
      svc <= 1'b0;
      n = 0;
      while (wdog !== 1'b1 && n < 100) begin
         @(posedge clk_i);
         #1 n++;
      end
      chk("wdog_slow", 8'(n), 8'(LSLOW));
      end_sim();
   end
endmodule
